// [acp_parser.v]
// Purpose: ASCII command line interpreter for a four channel conditioner board.
// Assumes: Byte stream from a same-clock receiver; AXI4-Lite for setup.
// Notes: Values are stored in tenths; one divider serves both gain equations.
// Operation
// - Unit or channel zero addresses all.
// - Directed set returns unit, name, ok.
// - Directed query returns the requested setting.
// - Global unit commands never answered.
// - Semicolon separated commands each execute, answer.
// - Later commands carry channel, reuse first unit.
// - Channel zero query lists every channel.
// - Unit-wide query reports board's lowest channel.
// - Both boards set; low board acknowledges.
// - High board silent on primary global query.
// - High board also answers at unit+128.
// - Gain accepted per fitted gain option.
// - Gain write recomputes full-scale input.
// - Sensitivity or input write recomputes gain.
// - Gain overrange adjusts full-scale input instead.
// - Gain query returns four values together.
// - Lamp test flashes indicators three times.
// - Read-only only queries; function type acts.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "acp_map.vh"
module acp_parser #(
	parameter [31:0] LAMP_HALF_CYC = `LAMP_HALF_CYC_DEF
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Command character stream
	input wire [7:0] rx_data,
	input wire rx_valid,
	output reg rx_ready,
	output reg [7:0] tx_data,
	output reg tx_valid,
	input wire tx_ready,
	// Front panel
	output reg lamp_on
);
	localparam M_RX = 3'h0, M_APPLY = 3'h1, M_DIV = 3'h2, M_FIX = 3'h3, M_TX = 3'h4;
	localparam P_UNIT = 3'h0, P_CHAN = 3'h1, P_NAME = 3'h2, P_VAL = 3'h3, P_EOL = 3'h4,
		P_SKIP = 3'h5;
	localparam T_UNIT = 4'h0, T_C1 = 4'h1, T_NAME = 4'h2, T_C2 = 4'h3, T_OK = 4'h4,
		T_CH = 4'h5, T_EQ = 4'h6, T_VAL = 4'h7, T_SEP = 4'h8, T_CR = 4'h9, T_LF = 4'hA,
		T_NUM = 4'hB, T_END = 4'hC;
	localparam C_NONE = 3'h0, C_GAIN = 3'h1, C_SENS = 3'h2, C_FSCI = 3'h3, C_FSCO = 3'h4,
		C_IEXC = 3'h5, C_STUS = 3'h6, C_LAMP = 3'h7;

	reg [2:0] m_st, p_st;
	reg [3:0] t_st, t_ret;
	reg [7:0] unit_reg, chan_reg, len_reg, unit_id_reg, cmd_cnt_reg;
	reg [31:0] name_reg;
	reg [15:0] val_reg, valx_reg, iexc_reg;
	reg op_q_reg, frac_reg, fdig_reg, ctrl_hi_reg, ctrl_inc_reg, resp_reg, qry_reg;
	reg [2:0] cmd_reg;
	reg [1:0] ci_reg, ce_reg, fld_reg, nidx_reg;
	reg [15:0] gain_mem [0:3];
	reg [15:0] sens_mem [0:3];
	reg [15:0] fs_in_mem [0:3];
	reg [15:0] fs_out_mem [0:3];
	reg [33:0] div_num;
	reg [32:0] div_rem;
	reg [31:0] div_den;
	reg [5:0] div_cnt;
	reg div_fs_in_reg;
	reg [19:0] nbcd;
	reg [2:0] ndig;
	reg nfrac, nlead, ndot, lamp_go_reg;
	reg [31:0] lamp_cnt;
	reg [2:0] lamp_ph;
	reg aw_have, w_have;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg [1:0] ci_first;
	reg uwide_r;
	integer i;

	function [15:0] dec_acc;
		input [15:0] old;
		input [7:0] c;
		reg [19:0] t;
		begin
			t = {4'h0, old} * 20'h0000A + {12'h000, c - `CH_ZERO};
			dec_acc = t[15:0];
		end
	endfunction

	function is_digit;
		input [7:0] c;
		begin
			is_digit = (c >= `CH_ZERO) && (c <= `CH_NINE);
		end
	endfunction

	function [2:0] cmd_of;
		input [31:0] n;
		begin
			case (n)
				`NAME_GAIN: cmd_of = C_GAIN;
				`NAME_SENS: cmd_of = C_SENS;
				`NAME_FSCI: cmd_of = C_FSCI;
				`NAME_FSCO: cmd_of = C_FSCO;
				`NAME_IEXC: cmd_of = C_IEXC;
				`NAME_STUS: cmd_of = C_STUS;
				`NAME_LAMP: cmd_of = C_LAMP;
				default: cmd_of = C_NONE;
			endcase
		end
	endfunction

	function [19:0] bin2bcd;
		input [15:0] b;
		integer j, k;
		reg [35:0] s;
		begin
			s = {20'h00000, b};
			for (j = 0; j < 16; j = j + 1) begin
				for (k = 0; k < 5; k = k + 1) begin
					if (s[16+4*k +: 4] > 4'h4) s[16+4*k +: 4] = s[16+4*k +: 4] + 4'h3;
				end
				s = s << 1;
			end
			bin2bcd = s[35:16];
		end
	endfunction

	// Address decision for the command that is about to execute.
	wire [2:0] cmd_now = cmd_of(name_reg);
	wire [7:0] base = ctrl_hi_reg ? `CH_BASE_HI : `CH_BASE_LO;
	wire [7:0] loc = chan_reg - base;
	wire own = loc < `CH_PER_BOARD;
	wire all_ch = chan_reg == 8'h00;
	wire g_unit = unit_reg == 8'h00;
	wire uwide = cmd_now == C_IEXC || cmd_now == C_STUS || cmd_now == C_LAMP;
	wire prim = unit_reg == unit_id_reg;
	wire sec = ctrl_hi_reg && unit_reg == unit_id_reg + `SEC_OFFSET;
	wire act = (g_unit || prim || sec) && (all_ch || own || uwide) && cmd_now != C_NONE;
	wire talk = act && !g_unit && (sec || !ctrl_hi_reg || (own && !uwide));
	wire [15:0] v10 = fdig_reg ? val_reg : dec_acc(val_reg, `CH_ZERO);
	wire gain_ok = ctrl_inc_reg ? (valx_reg >= `GAIN_MIN && valx_reg <= `GAIN_MAX_INC) :
		(valx_reg == `GAIN_X1 || valx_reg == `GAIN_X10 || valx_reg == `GAIN_X100);
	wire [15:0] gmax = ctrl_inc_reg ? `GAIN_MAX_INC : `GAIN_X100;
	wire [32:0] div_tr = {div_rem[31:0], div_num[33]};
	wire div_ge = div_tr >= {1'b0, div_den};
	wire [15:0] q16 = (|div_num[33:16]) ? 16'hFFFF : div_num[15:0];
	wire [7:0] rc = rx_data;
	wire [15:0] unit_acc = dec_acc({8'h00, unit_reg}, rc);
	wire [15:0] chan_acc = dec_acc({8'h00, chan_reg}, rc);

	reg [15:0] fval;
	always @* begin
		case (cmd_reg)
			C_GAIN: begin
				case (fld_reg)
					2'h0: fval = gain_mem[ci_reg];
					2'h1: fval = sens_mem[ci_reg];
					2'h2: fval = fs_out_mem[ci_reg];
					default: fval = fs_in_mem[ci_reg];
				endcase
			end
			C_SENS: fval = sens_mem[ci_reg];
			C_FSCI: fval = fs_in_mem[ci_reg];
			C_FSCO: fval = fs_out_mem[ci_reg];
			C_IEXC: fval = iexc_reg;
			default: fval = {15'h0000, lamp_ph != 3'h0};
		endcase
	end

	task emit;
		input [7:0] c;
		begin
			tx_valid <= 1'b1;
			tx_data <= c;
		end
	endtask

	task num_go;
		input [15:0] v;
		input f;
		input [3:0] ret;
		begin
			nbcd <= bin2bcd(v);
			ndig <= 3'h4;
			nfrac <= f;
			nlead <= 1'b0;
			ndot <= 1'b0;
			t_ret <= ret;
			t_st <= T_NUM;
		end
	endtask

	task div_go;
		input [33:0] n;
		input [31:0] d;
		input to_fs_in;
		begin
			div_num <= n;
			div_den <= d;
			div_rem <= 33'h000000000;
			div_cnt <= 6'h00;
			div_fs_in_reg <= to_fs_in;
			m_st <= M_DIV;
		end
	endtask

	task chan_next;
		begin
			if (ci_reg == ce_reg) begin
				ci_reg <= ce_reg == ci_reg && !uwide_r ? ci_first : ci_reg;
				t_st <= T_UNIT;
				m_st <= resp_reg ? M_TX : M_RX;
				rx_ready <= !resp_reg;
			end else begin
				ci_reg <= ci_reg + 2'h1;
				m_st <= M_APPLY;
			end
		end
	endtask

	// Command engine: parse, apply, divide, answer.
	always @(posedge aclk) begin
		if (!aresetn) begin
			m_st <= M_RX;
			p_st <= P_UNIT;
			t_st <= T_UNIT;
			t_ret <= T_UNIT;
			unit_reg <= 8'h00;
			chan_reg <= 8'h00;
			len_reg <= 8'h00;
			cmd_cnt_reg <= 8'h00;
			name_reg <= 32'h00000000;
			val_reg <= 16'h0000;
			valx_reg <= 16'h0000;
			iexc_reg <= `IEXC_RST;
			op_q_reg <= 1'b0;
			frac_reg <= 1'b0;
			fdig_reg <= 1'b0;
			resp_reg <= 1'b0;
			qry_reg <= 1'b0;
			cmd_reg <= C_NONE;
			ci_reg <= 2'h0;
			ce_reg <= 2'h0;
			ci_first <= 2'h0;
			uwide_r <= 1'b0;
			fld_reg <= 2'h0;
			nidx_reg <= 2'h0;
			div_num <= 34'h000000000;
			div_rem <= 33'h000000000;
			div_den <= 32'h00000000;
			div_cnt <= 6'h00;
			div_fs_in_reg <= 1'b0;
			nbcd <= 20'h00000;
			ndig <= 3'h0;
			nfrac <= 1'b0;
			nlead <= 1'b0;
			ndot <= 1'b0;
			lamp_go_reg <= 1'b0;
			rx_ready <= 1'b1;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			for (i = 0; i < 4; i = i + 1) begin
				gain_mem[i] <= `GAIN_RST;
				sens_mem[i] <= `SENS_RST;
				fs_in_mem[i] <= `FS_IN_RST;
				fs_out_mem[i] <= `FS_OUT_RST;
			end
		end else begin
			lamp_go_reg <= 1'b0;
			if (tx_valid && tx_ready) tx_valid <= 1'b0;
			case (m_st)
				M_RX: begin
					if (rx_valid && rx_ready) begin
						len_reg <= len_reg + 8'h01;
						if (p_st != P_SKIP && p_st != P_EOL && len_reg == `MAX_LEN && rc != `CH_CR) begin
							p_st <= P_SKIP;
						end else begin
							case (p_st)
								P_UNIT: begin
									if (is_digit(rc)) unit_reg <= unit_acc[7:0];
									else if (rc == `CH_COLON) begin
										p_st <= P_CHAN;
										chan_reg <= 8'h00;
									end
								end
								P_CHAN: begin
									if (is_digit(rc)) chan_reg <= chan_acc[7:0];
									else if (rc == `CH_COLON) begin
										p_st <= P_NAME;
										name_reg <= 32'h00000000;
									end
								end
								P_NAME: begin
									if (rc == `CH_EQ || rc == `CH_QUERY) begin
										op_q_reg <= rc == `CH_QUERY;
										p_st <= P_VAL;
										val_reg <= 16'h0000;
										frac_reg <= 1'b0;
										fdig_reg <= 1'b0;
									end else if (rc == `CH_CR) p_st <= P_EOL;
									else if (rc != `CH_SPACE) name_reg <= {name_reg[23:0], rc};
								end
								P_VAL: begin
									if (is_digit(rc) && (!frac_reg || !fdig_reg)) begin
										val_reg <= dec_acc(val_reg, rc);
										fdig_reg <= frac_reg;
									end else if (rc == `CH_DOT) frac_reg <= 1'b1;
									else if (rc == `CH_SEMI || rc == `CH_CR) begin
										p_st <= rc == `CH_SEMI ? P_CHAN : P_EOL;
										chan_reg <= 8'h00;
										valx_reg <= v10;
										if (act) begin
											cmd_cnt_reg <= cmd_cnt_reg + 8'h01;
											cmd_reg <= cmd_now;
											uwide_r <= uwide;
											ci_reg <= (all_ch || uwide) ? 2'h0 : loc[1:0];
											ci_first <= (all_ch || uwide) ? 2'h0 : loc[1:0];
											ce_reg <= uwide ? 2'h0 : (all_ch ? `CH_LAST : loc[1:0]);
											resp_reg <= talk;
											t_st <= T_UNIT;
											// Read-only names answer as queries; function names act.
											qry_reg <= (op_q_reg || cmd_now == C_STUS) && cmd_now != C_LAMP;
											if (cmd_now == C_LAMP) begin
												lamp_go_reg <= 1'b1;
												m_st <= talk ? M_TX : M_RX;
												rx_ready <= !talk;
											end else if (op_q_reg || cmd_now == C_STUS) begin
												m_st <= talk ? M_TX : M_RX;
												rx_ready <= !talk;
											end else begin
												m_st <= M_APPLY;
												rx_ready <= 1'b0;
											end
										end
									end
								end
								default: begin
									if (rc == `CH_LF) begin
										p_st <= P_UNIT;
										unit_reg <= 8'h00;
										len_reg <= 8'h00;
									end
								end
							endcase
						end
					end
				end
				M_APPLY: begin
					case (cmd_reg)
						C_GAIN: begin
							if (gain_ok) begin
								gain_mem[ci_reg] <= valx_reg;
								div_go({18'h00000, fs_out_mem[ci_reg]} * `SCALE_K,
									{16'h0000, valx_reg} * {16'h0000, sens_mem[ci_reg]}, 1'b1);
							end else chan_next;
						end
						C_SENS: begin
							sens_mem[ci_reg] <= valx_reg;
							div_go({18'h00000, fs_out_mem[ci_reg]} * `SCALE_K,
								{16'h0000, fs_in_mem[ci_reg]} * {16'h0000, valx_reg}, 1'b0);
						end
						C_FSCI: begin
							fs_in_mem[ci_reg] <= valx_reg;
							div_go({18'h00000, fs_out_mem[ci_reg]} * `SCALE_K,
								{16'h0000, valx_reg} * {16'h0000, sens_mem[ci_reg]}, 1'b0);
						end
						C_FSCO: begin
							fs_out_mem[ci_reg] <= valx_reg;
							div_go({18'h00000, valx_reg} * `SCALE_K,
								{16'h0000, fs_in_mem[ci_reg]} * {16'h0000, sens_mem[ci_reg]}, 1'b0);
						end
						C_IEXC: begin
							iexc_reg <= valx_reg;
							chan_next;
						end
						default: chan_next;
					endcase
				end
				M_DIV: begin
					if (div_cnt == `DIV_BITS) m_st <= M_FIX;
					else begin
						div_cnt <= div_cnt + 6'h01;
						div_rem <= div_ge ? div_tr - {1'b0, div_den} : div_tr;
						div_num <= {div_num[32:0], div_ge};
					end
				end
				M_FIX: begin
					if (div_fs_in_reg) begin
						fs_in_mem[ci_reg] <= q16;
						chan_next;
					end else if (q16 > gmax || q16 < `GAIN_MIN) begin
						gain_mem[ci_reg] <= q16 > gmax ? gmax : `GAIN_MIN;
						div_go({18'h00000, fs_out_mem[ci_reg]} * `SCALE_K,
							{16'h0000, (q16 > gmax ? gmax : `GAIN_MIN)} *
							{16'h0000, sens_mem[ci_reg]}, 1'b1);
					end else begin
						gain_mem[ci_reg] <= q16;
						chan_next;
					end
				end
				default: begin
					if (!tx_valid) begin
						case (t_st)
							T_UNIT: num_go({8'h00, unit_reg}, 1'b0, T_C1);
							T_C1: begin
								emit(`CH_COLON);
								nidx_reg <= 2'h3;
								t_st <= T_NAME;
							end
							T_NAME: begin
								emit(name_reg[nidx_reg*8 +: 8]);
								if (nidx_reg == 2'h0) t_st <= T_C2;
								else nidx_reg <= nidx_reg - 2'h1;
							end
							T_C2: begin
								emit(`CH_COLON);
								nidx_reg <= 2'h1;
								t_st <= qry_reg ? T_CH : T_OK;
							end
							T_OK: begin
								emit(nidx_reg[0] ? `CH_O : `CH_K);
								nidx_reg <= 2'h0;
								if (!nidx_reg[0]) t_st <= T_CR;
							end
							T_CH: begin
								fld_reg <= 2'h0;
								num_go({8'h00, base + {6'h00, ci_reg}}, 1'b0, T_EQ);
							end
							T_EQ: begin
								emit(`CH_EQ);
								t_st <= T_VAL;
							end
							T_VAL: num_go(fval, 1'b1, T_SEP);
							T_SEP: begin
								if (cmd_reg == C_GAIN && fld_reg != 2'h3) begin
									emit(`CH_COLON);
									fld_reg <= fld_reg + 2'h1;
									t_st <= T_VAL;
								end else begin
									emit(`CH_SEMI);
									if (ci_reg == ce_reg) t_st <= T_CR;
									else begin
										ci_reg <= ci_reg + 2'h1;
										t_st <= T_CH;
									end
								end
							end
							T_CR: begin
								emit(`CH_CR);
								t_st <= T_LF;
							end
							T_LF: begin
								emit(`CH_LF);
								t_st <= T_END;
							end
							// Input resumes only once the last answer byte has left.
							T_END: begin
								t_st <= T_UNIT;
								m_st <= M_RX;
								rx_ready <= 1'b1;
							end
							default: begin
								if (nfrac && ndig == 3'h0 && !ndot) begin
									emit(`CH_DOT);
									ndot <= 1'b1;
								end else begin
									if (nbcd[ndig*4 +: 4] != 4'h0 || nlead || ndig == 3'h0 ||
										(nfrac && ndig == 3'h1)) begin
										emit(`CH_ZERO + {4'h0, nbcd[ndig*4 +: 4]});
										nlead <= 1'b1;
									end
									if (ndig == 3'h0) t_st <= t_ret;
									else ndig <= ndig - 3'h1;
								end
							end
						endcase
					end
				end
			endcase
		end
	end

	// Lamp test: five half-period toggles give three lit flashes.
	always @(posedge aclk) begin
		if (!aresetn) begin
			lamp_cnt <= 32'h00000000;
			lamp_ph <= 3'h0;
			lamp_on <= 1'b0;
		end else if (lamp_go_reg) begin
			lamp_cnt <= 32'h00000000;
			lamp_ph <= `LAMP_HALVES;
			lamp_on <= 1'b1;
		end else if (lamp_ph != 3'h0) begin
			if (lamp_cnt == LAMP_HALF_CYC - 32'h00000001) begin
				lamp_cnt <= 32'h00000000;
				lamp_on <= !lamp_on;
				lamp_ph <= lamp_ph - 3'h1;
			end else lamp_cnt <= lamp_cnt + 32'h00000001;
		end
	end

	// AXI4-Lite register access.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			unit_id_reg <= `UNIT_ID_RST;
			ctrl_hi_reg <= 1'b0;
			ctrl_inc_reg <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_have <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_have <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have && w_have && !s_axi_bvalid) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (aw_addr[7:2] == `ADDR_CTRL >> 2) begin
					if (w_strb[0]) unit_id_reg <= w_data[7:0];
					if (w_strb[1]) begin
						ctrl_hi_reg <= w_data[`CTRL_HI_BIT];
						ctrl_inc_reg <= w_data[`CTRL_INC_BIT];
					end
				end else if (aw_addr[7:2] != `ADDR_STAT >> 2) s_axi_bresp <= `RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				if (s_axi_araddr[7:2] == `ADDR_CTRL >> 2)
					s_axi_rdata <= {22'h000000, ctrl_inc_reg, ctrl_hi_reg, unit_id_reg};
				else if (s_axi_araddr[7:2] == `ADDR_STAT >> 2)
					s_axi_rdata <= {16'h0000, cmd_cnt_reg, 6'h00, lamp_ph != 3'h0, m_st != M_RX};
				else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// [acp_map.vh]
// Purpose: Constants shared by the ASCII command parser.
// Assumes: A 10 MHz system clock; channel values held in tenths.
// Notes: Definitions only.
`ifndef ACP_MAP_VH
`define ACP_MAP_VH
`define CLK_HZ 10000000
`define LAMP_HALF_MS 250
`define LAMP_HALF_CYC_DEF (`LAMP_HALF_MS * (`CLK_HZ / 1000))
`define LAMP_HALVES 3'h5
`define ADDR_CTRL 8'h00
`define ADDR_STAT 8'h04
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define UNIT_ID_RST 8'h01
`define SEC_OFFSET 8'h80
`define CH_BASE_LO 8'h01
`define CH_BASE_HI 8'h05
`define CH_PER_BOARD 8'h04
`define CH_LAST 2'h3
`define MAX_LEN 8'hFF
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_COLON 8'h3A
`define CH_SEMI 8'h3B
`define CH_EQ 8'h3D
`define CH_QUERY 8'h3F
`define CH_DOT 8'h2E
`define CH_ZERO 8'h30
`define CH_NINE 8'h39
`define CH_SPACE 8'h20
`define CH_O 8'h6F
`define CH_K 8'h6B
`define NAME_GAIN 32'h4741494E
`define NAME_SENS 32'h53454E53
`define NAME_FSCI 32'h46534349
`define NAME_FSCO 32'h4653434F
`define NAME_IEXC 32'h49455843
`define NAME_STUS 32'h53545553
`define NAME_LAMP 32'h4C454453
`define GAIN_RST 16'h000A
`define SENS_RST 16'h0064
`define FS_OUT_RST 16'h0064
`define FS_IN_RST 16'h2710
`define IEXC_RST 16'h0028
`define GAIN_MIN 16'h0001
`define GAIN_MAX_INC 16'h07D0
`define GAIN_X1 16'h000A
`define GAIN_X10 16'h0064
`define GAIN_X100 16'h03E8
`define SCALE_K 34'h00186A0
`define DIV_BITS 6'h22
`define CTRL_HI_BIT 8
`define CTRL_INC_BIT 9
`endif

// [acp_properties.sv]
// Purpose: Port-level checks on the command parser.
// Assumes: One clock domain with an active-low synchronous reset.
// Notes: Bound to every acp_parser instance below.
`timescale 1ns/100ps
module acp_properties #(
	parameter [31:0] LAMP_HALF_CYC = 32'h8
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Character streams and lamp
	input wire rx_ready,
	input wire [7:0] tx_data,
	input wire tx_valid,
	input wire tx_ready,
	input wire lamp_on
);
	reg [31:0] hi_cnt;
	reg [31:0] lo_cnt;
	reg [3:0] lit_cnt;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A lamp test counts as over once the lamp stays dark for three half periods.
	always @(posedge aclk) begin
		if (!aresetn) begin
			hi_cnt <= 32'h0;
			lo_cnt <= 32'h0;
			lit_cnt <= 4'h0;
		end else begin
			hi_cnt <= lamp_on ? hi_cnt + 32'h1 : 32'h0;
			lo_cnt <= lamp_on ? 32'h0 : lo_cnt + 32'h1;
			if ($rose(lamp_on))
				lit_cnt <= lit_cnt + 4'h1;
			else if (lo_cnt > 3 * LAMP_HALF_CYC)
				lit_cnt <= 4'h0;
		end
	end
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not offered after address");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped before taken");
	AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("answer byte changed before taken");
	AST_TX_STALLS_RX: assert property (tx_valid |-> !rx_ready)
		else $error("input taken while answering");
	AST_LAMP_RUN: assert property (hi_cnt <= LAMP_HALF_CYC + 32'h2)
		else $error("lamp lit phase too long");
	AST_LAMP_THREE: assert property (lit_cnt <= 4'h3)
		else $error("more than three lamp flashes");
	cover property ($rose(lamp_on));
	cover property (tx_valid && !tx_ready);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind acp_parser acp_properties #(.LAMP_HALF_CYC(LAMP_HALF_CYC)) u_props (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_ready(rx_ready),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .lamp_on(lamp_on)
);

// [acp_host_model.sv]
// Purpose: Host computer model on the command character link.
// Assumes: Same clock as the parser; one byte offered at a time.
// Notes: Slow mode takes an answer byte one cycle in four.
`timescale 1ns/100ps
module acp_host_model (
	// Clock
	input wire aclk,
	// Commands toward the parser
	output reg [7:0] rx_data,
	output reg rx_valid,
	input wire rx_ready,
	// Answers from the parser
	input wire [7:0] tx_data,
	input wire tx_valid,
	output reg tx_ready,
	// Pacing
	input wire slow
);
	reg [1:0] pace = 2'h0;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	always @(posedge aclk) begin
		pace <= pace + 2'h1;
		tx_ready <= !slow || pace == 2'h3;
	end
	// An idle line shows the inverse of the last byte, never a stale copy.
	task send_byte(input [7:0] b);
		begin
			@(posedge aclk);
			rx_data <= b;
			rx_valid <= 1'b1;
			@(posedge aclk);
			while (rx_ready !== 1'b1) @(posedge aclk);
			rx_valid <= 1'b0;
			rx_data <= ~b;
		end
	endtask
	// The line goes out byte by byte, pausing while rx_ready is low, and ends in CR LF.
	task send_line(input string s);
		begin
			for (int i = 0; i < s.len(); i++) send_byte(s[i]);
			send_byte(8'h0D);
			send_byte(8'h0A);
		end
	endtask
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the command parser.
// Assumes: Lamp half period cut to 8 cycles.
// Notes: Answer bytes are checked against a queue of expected bytes.
`timescale 1ns/100ps
`include "acp_map.vh"
module testbench;
	reg aclk = 1'b0;
	reg aresetn = 1'b0;
	reg [7:0] awaddr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg [3:0] wstrb = 4'h0;
	reg awvalid = 1'b0;
	reg wvalid = 1'b0;
	reg bready = 1'b0;
	reg [7:0] araddr = 8'h00;
	reg arvalid = 1'b0;
	reg rready = 1'b0;
	reg slow = 1'b0;
	wire awready, wready, bvalid, arready, rvalid;
	wire rx_valid, rx_ready, tx_valid, tx_ready, lamp_on;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] rx_data, tx_data;
	reg [7:0] exp_q[$];
	reg [7:0] uid = 8'h00;
	string s;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int rises = 0;
	always #50 aclk = ~aclk;
	always @(posedge lamp_on) rises++;
	acp_parser #(.LAMP_HALF_CYC(32'h8)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .lamp_on(lamp_on)
	);
	acp_host_model u_host (
		.aclk(aclk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow)
	);
	task print_verdict;
		begin
			if (num_errors == 0 && comparisons > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task check(input string n, input [31:0] e, input [31:0] g);
		begin
			comparisons++;
			if (g !== e) begin
				num_errors++;
				$display("[FAIL] %s expected %0h seen %0h", n, e, g);
			end
		end
	endtask
	task axi_write(input [7:0] a, input [31:0] d, input [1:0] er);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			wstrb <= 4'hF;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			@(posedge aclk);
			while (awvalid || wvalid) begin
				if (awready === 1'b1) awvalid <= 1'b0;
				if (wready === 1'b1) wvalid <= 1'b0;
				@(posedge aclk);
			end
			while (bvalid !== 1'b1) @(posedge aclk);
			check("bresp", {30'h0, er}, {30'h0, bresp});
			bready <= 1'b0;
		end
	endtask
	task axi_read(input [7:0] a, input [31:0] ed, input [1:0] er);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			@(posedge aclk);
			while (arready !== 1'b1) @(posedge aclk);
			arvalid <= 1'b0;
			@(posedge aclk);
			while (rvalid !== 1'b1) @(posedge aclk);
			check("rdata", ed, rdata);
			check("rresp", {30'h0, er}, {30'h0, rresp});
			rready <= 1'b0;
		end
	endtask
	// Waits until every expected byte came and the parser idles for 30 cycles.
	task quiet;
		int n;
		begin
			n = 0;
			while (n < 30) begin
				@(posedge aclk);
				n = (exp_q.size() == 0 && tx_valid === 1'b0 && rx_ready === 1'b1) ? n + 1 : 0;
			end
		end
	endtask
	// In the answer text a bar stands for CR LF.
	task run(input string m, input string r);
		begin
			for (int i = 0; i < r.len(); i++) begin
				if (r[i] == "|") begin
					exp_q.push_back(`CH_CR);
					exp_q.push_back(`CH_LF);
				end else
					exp_q.push_back(r[i]);
			end
			u_host.send_line(m);
			quiet;
		end
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			$display("[FAIL] cycles expected below 30000 seen %0d", cycles);
			print_verdict;
		end
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			check("tx_data", exp_q.size() ? {24'h0, exp_q.pop_front()} : 32'h100,
				{24'h0, tx_data});
	end
	initial begin
		void'($urandom(66703));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(`ADDR_CTRL, 32'h201, `RESP_OKAY);
		axi_read(8'h08, 32'h0, `RESP_SLVERR);
		axi_write(8'h0C, 32'h5, `RESP_SLVERR);
		axi_write(`ADDR_STAT, 32'hFFFF, `RESP_OKAY);
		axi_read(`ADDR_CTRL, 32'h201, `RESP_OKAY);
		run("1:1:SENS?", "1:SENS:1=10.0;|");
		run("1:1:SENS=5;2:SENS?", "1:SENS:ok|1:SENS:2=10.0;|");
		run("0:1:SENS=4", "");
		run("3:1:SENS=6", "");
		run("1:1:GAIN?", "1:GAIN:1=2.5:4.0:10.0:1000.0;|");
		run("1:3:GAIN=20;3:FSCI?", "1:GAIN:ok|1:FSCI:3=50.0;|");
		run("1:2:IEXC?", "1:IEXC:1=4.0;|");
		slow <= 1'b1;
		run("1:0:FSCO?", "1:FSCO:1=10.0;2=10.0;3=10.0;4=10.0;|");
		slow <= 1'b0;
		s = "1:1:SENS=7";
		repeat (246) s = {s, " "};
		run(s, "");
		run("1:1:SENS?", "1:SENS:1=4.0;|");
		axi_write(`ADDR_CTRL, 32'h1, `RESP_OKAY);
		run("1:4:GAIN=5;4:GAIN?;4:GAIN=100;4:FSCI?",
			"1:GAIN:ok|1:GAIN:4=1.0:10.0:10.0:1000.0;|1:GAIN:ok|1:FSCI:4=10.0;|");
		axi_write(`ADDR_CTRL, 32'h301, `RESP_OKAY);
		run("1:0:SENS=8;0:SENS?", "");
		s = $sformatf("%s%s", "129:SENS:5=8.0;6=8.0;7=8.0;8=8.0;|",
			"129:SENS:ok|129:GAIN:8=200.0:0.1:10.0:500.0;|");
		run("129:0:SENS?;8:SENS=0.1;8:GAIN?", s);
		axi_write(`ADDR_CTRL, 32'h201, `RESP_OKAY);
		run("1:2:SENS?", "1:SENS:2=8.0;|");
		rises = 0;
		run($sformatf("1:0:%s=0", `NAME_LAMP),
			$sformatf("1:%s:ok|", `NAME_LAMP));
		repeat (80) @(posedge aclk);
		check("lamp_on rises", 32'h3, rises);
		run("1:1:STUS=1", "1:STUS:1=0.0;|");
		uid = 8'h02 + 8'($urandom % 120);
		axi_write(`ADDR_CTRL, {22'h0, 2'h2, uid}, `RESP_OKAY);
		run($sformatf("%0d:3:IEXC?", uid), $sformatf("%0d:IEXC:1=4.0;|", uid));
		run("1:1:IEXC?", "");
		axi_read(`ADDR_STAT, 32'h1700, `RESP_OKAY);
		print_verdict;
	end
endmodule
